// ---- core/mcc_div_if.sv ----
/*
 Carrier between the controller and one of its prescalers.
 Assumes tick_in is a one-cycle enable on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface mcc_div_if;
    logic       tick_in;
    logic [2:0] shift;
    logic       tick_out;
    modport src (output tick_in, output shift, input tick_out);
    modport div (input tick_in, input shift, output tick_out);
endinterface
`default_nettype wire

// ---- core/mcc_pkg.sv ----
/*
 Shared constants for the clock controller: source codes, reset values,
 timing counts and small decode helpers.
 Assumes one 250 MHz core clock; every slower rate is a one-cycle enable.
*/
// Functional notes
// - Software prescaler divides core and peripheral clocks
// - Source switch on the fly, no glitches
// - Gate core, each peripheral, memory separately
// - Master from crystal, 16 MHz RC, multispeed RC
// - PLL reference: fast crystal or 16 MHz RC
// - Multispeed RC: seven binary-stepped ranges
// - Both internal fast RCs have software trim
// - Multispeed RC trimmable against 32 kHz crystal
// - 37 kHz RC clocks watchdog, RTC, LCD
// - 37 kHz RC measured against 16 MHz RC
// - RTC/LCD source chosen independently of master
// - USB 48 MHz RC trimmed from SOF
// - Reset starts on multispeed RC at 2 MHz
// - Crystal failure forces 16 MHz RC, interrupt
// - 32 kHz crystal failure gives interrupt or wakeup
// - Selected internal clock drives clock output pin
// - AHB, APB1, APB2 prescalers, max 32 MHz
`default_nettype none
package mcc_pkg;
    localparam int unsigned CORE_PERIOD_NS = 4;

    // Oscillator tick indices; low three match the master source codes
    localparam int unsigned OSC_MSRC   = 0;
    localparam int unsigned OSC_INT16  = 1;
    localparam int unsigned OSC_EXTF   = 2;
    localparam int unsigned OSC_EXT32K = 3;
    localparam int unsigned OSC_INT37K = 4;
    localparam int unsigned OSC_INT48  = 5;
    localparam int unsigned NOSC       = 6;
    // Ready levels sit above the clocks in the synchroniser vector
    localparam int unsigned RDY_BASE   = 6;
    localparam int unsigned NSYNC      = 10;

    localparam logic [1:0] SRC_MSRC  = 2'h0;
    localparam logic [1:0] SRC_INT16 = 2'h1;
    localparam logic [1:0] SRC_EXTF  = 2'h2;
    localparam logic [1:0] SRC_RSVD  = 2'h3;

    localparam logic [1:0] LS_OFF    = 2'h0;
    localparam logic [1:0] LS_EXT32K = 2'h1;
    localparam logic [1:0] LS_INT37K = 2'h2;
    localparam logic [1:0] LS_EXTF   = 2'h3;

    localparam logic [2:0] MCO_OFF    = 3'h0;
    localparam logic [2:0] MCO_MASTER = 3'h1;
    localparam logic [2:0] MCO_INT16  = 3'h2;
    localparam logic [2:0] MCO_MSRC   = 3'h3;
    localparam logic [2:0] MCO_EXTF   = 3'h4;
    localparam logic [2:0] MCO_EXT32K = 3'h5;
    localparam logic [2:0] MCO_INT37K = 3'h6;
    localparam logic [2:0] MCO_INT48  = 3'h7;

    localparam logic [2:0] MSRC_RANGE_RST = 3'h5;
    localparam logic [2:0] MSRC_RANGE_MAX = 3'h6;
    localparam logic [5:0] OSC_EN_RST     = 6'h11;
    localparam logic [5:0] USB_TRIM_RST   = 6'h20;
    localparam logic [5:0] USB_TRIM_MAX   = 6'h3f;
    localparam logic [4:0] INT16_TRIM_RST = 5'h10;
    localparam logic [7:0] MSRC_TRIM_RST  = 8'h00;

    localparam int unsigned EXTF_LOSS_NS    = 2000;
    localparam int unsigned EXTF_LOSS_CYC   = (EXTF_LOSS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int unsigned EXT32K_LOSS_NS  = 100000;
    localparam int unsigned EXT32K_LOSS_CYC =
        (EXT32K_LOSS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int unsigned USB_SOF_NS      = 1000000;
    localparam int unsigned INT48_MHZ       = 48;
    localparam int unsigned INT48_PER_SOF   = USB_SOF_NS * INT48_MHZ / 1000;
    localparam int unsigned USB_TRIM_TOL    = 24;

    function automatic logic [6:0] div_mask(input logic [2:0] shift);
        logic [7:0] t;
        t = 8'h01 << shift;
        return 7'(t - 8'h01);
    endfunction

    function automatic logic pick3(input logic [1:0] sel, input logic [2:0] v);
        return (sel == SRC_RSVD) ? 1'b0 : v[sel];
    endfunction
endpackage
`default_nettype wire

// ---- core/mcc_prescaler.sv ----
/*
 Power-of-two enable divider: one output tick per 2^shift input ticks.
 Assumes shift may change at any time; the count restarts cleanly.
*/
`timescale 1ns/100ps
`default_nettype none
module mcc_prescaler
    import mcc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic resetn,
    mcc_div_if.div    dv
);
    logic [6:0] cnt_q, cnt_d;
    logic       tick_q, tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (dv.tick_in) begin
            // Greater-or-equal so a smaller ratio never strands the count
            if (cnt_q >= div_mask(dv.shift)) begin
                cnt_d  = 7'h00;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 7'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign dv.tick_out = tick_q;
endmodule // mcc_prescaler
`default_nettype wire

// ---- core/mcc_sync.sv ----
/*
 Three-stage synchroniser with agreement filter and rising-edge pulse.
 Assumes din is asynchronous to core_clk and slower than a quarter of its rate.
*/
`timescale 1ns/100ps
`default_nettype none
module mcc_sync #(
    parameter int unsigned W = 1
)(
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] level,
    output var  logic [W-1:0] rise
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q;
    logic [W-1:0] lvl_d, rise_d;

    // Only s2/s3 are compared; s1 may be metastable
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) lvl_d[i] = s3_q[i];
        end
        rise_d = lvl_d & ~lvl_q;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            lvl_q  <= '0;
            rise_q <= '0;
        end else begin
            s1_q   <= din;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            lvl_q  <= lvl_d;
            rise_q <= rise_d;
        end
    end

    assign level = lvl_q;
    assign rise  = rise_q;
endmodule // mcc_sync
`default_nettype wire

// ---- core/mcc_top.sv ----
/*
 Clock controller: master source switch, prescalers, gating, low-speed and
 USB clock selection, failure monitors, measurement and clock output.
 Assumes oscillators arrive as asynchronous levels with ready flags and
 that software settings are static levels on core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module mcc_top
    import mcc_pkg::*;
#(
    parameter int unsigned LSE_LOSS_CYC = EXT32K_LOSS_CYC
)(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [5:0]  osc_clk_in,
    input  wire logic [3:0]  osc_rdy_in,
    input  wire logic [1:0]  master_clock_sel,
    input  wire logic [2:0]  msrc_range,
    input  wire logic [4:0]  int16_trim_in,
    input  wire logic [7:0]  msrc_trim_in,
    input  wire logic [2:0]  ahb_shift,
    input  wire logic [2:0]  apb1_shift,
    input  wire logic [2:0]  apb2_shift,
    input  wire logic        core_gate_en,
    input  wire logic [7:0]  periph_gate_en,
    input  wire logic        mem_gate_en,
    input  wire logic        pll_ref_sel,
    input  wire logic [1:0]  ls_sel,
    input  wire logic [2:0]  mco_sel,
    input  wire logic        css_en,
    input  wire logic        css_irq_en,
    input  wire logic        css_clr,
    input  wire logic        lse_css_en,
    input  wire logic        lse_irq_en,
    input  wire logic        lse_wkup_en,
    input  wire logic        lse_clr,
    input  wire logic        meas_en,
    input  wire logic        usb_en,
    input  wire logic        usb_sof,
    output logic [5:0]  osc_en,
    output logic [2:0]  msrc_range_out,
    output logic [4:0]  int16_trim_out,
    output logic [7:0]  msrc_trim_out,
    output logic [5:0]  usb_trim_out,
    output logic [1:0]  master_clock_cur,
    output logic        switch_busy,
    output logic        master_tick,
    output logic        ahb_tick,
    output logic        apb1_tick,
    output logic        apb2_tick,
    output logic        core_tick,
    output logic [7:0]  periph_tick,
    output logic        mem_tick,
    output logic        pll_ref_tick,
    output logic        rtc_lcd_tick,
    output logic        iwdg_tick,
    output logic        usb_tick,
    output logic [15:0] msrc_meas,
    output logic [15:0] lsi_meas,
    output logic [1:0]  meas_valid,
    output logic        css_flag,
    output logic        css_irq,
    output logic        lse_flag,
    output logic        lse_irq,
    output logic        lse_wkup,
    output logic        clock_output_pin
);
    typedef enum logic [1:0] {SW_IDLE, SW_WAIT_RDY, SW_ALIGN} mcc_sw_e;

    logic [NSYNC-1:0] sync_lvl;
    logic [NSYNC-1:0] sync_rise;
    logic [NOSC-1:0]  rise;
    logic [2:0]       rise3;
    logic [2:0]       rdy3;

    mcc_sync #(.W(NSYNC)) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .din      ({osc_rdy_in, osc_clk_in}),
        .level    (sync_lvl),
        .rise     (sync_rise)
    );

    assign rise  = sync_rise[NOSC-1:0];
    assign rise3 = rise[2:0];
    assign rdy3  = sync_lvl[RDY_BASE+2:RDY_BASE];

    // Configuration
    logic [2:0] range_q, range_d;
    logic [4:0] int16_trim_q, int16_trim_d;
    logic [7:0] msrc_trim_q, msrc_trim_d;

    always_comb begin
        range_d      = range_q;
        if (msrc_range <= MSRC_RANGE_MAX) range_d = msrc_range;
        int16_trim_d = int16_trim_in;
        msrc_trim_d  = msrc_trim_in;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            range_q      <= MSRC_RANGE_RST;
            int16_trim_q <= INT16_TRIM_RST;
            msrc_trim_q  <= MSRC_TRIM_RST;
        end else begin
            range_q      <= range_d;
            int16_trim_q <= int16_trim_d;
            msrc_trim_q  <= msrc_trim_d;
        end
    end

    // Master source switch
    mcc_sw_e    sw_st_q, sw_st_d;
    logic [1:0] cur_q, cur_d, tgt_q, tgt_d, req;
    logic       css_flag_q, css_flag_d;

    always_comb begin
        req = master_clock_sel;
        if (master_clock_sel == SRC_RSVD) req = cur_q;
        // A failed crystal stays locked out until the flag is cleared
        if (css_flag_q && (req == SRC_EXTF)) req = SRC_INT16;
        sw_st_d = sw_st_q;
        cur_d   = cur_q;
        tgt_d   = tgt_q;
        case (sw_st_q)
            SW_IDLE: begin
                if (req != cur_q) begin
                    tgt_d   = req;
                    sw_st_d = SW_WAIT_RDY;
                end
            end
            SW_WAIT_RDY: begin
                if (req != tgt_q) sw_st_d = SW_IDLE;
                else if (pick3(tgt_q, rdy3)) sw_st_d = SW_ALIGN;
            end
            SW_ALIGN: begin
                if (req != tgt_q) begin
                    sw_st_d = SW_IDLE;
                end else if (pick3(tgt_q, rise3)) begin
                    cur_d   = tgt_q;
                    sw_st_d = SW_IDLE;
                end
            end
            default: sw_st_d = SW_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sw_st_q <= SW_IDLE;
            cur_q   <= SRC_MSRC;
            tgt_q   <= SRC_MSRC;
        end else begin
            sw_st_q <= sw_st_d;
            cur_q   <= cur_d;
            tgt_q   <= tgt_d;
        end
    end

    // Failure monitors; a new failure wins over a clear in the same cycle
    logic [9:0]  extf_cnt_q, extf_cnt_d;
    logic [15:0] lse_cnt_q, lse_cnt_d;
    logic        css_trip, lse_trip;
    logic        css_irq_q, css_irq_d, lse_flag_q, lse_flag_d;
    logic        lse_irq_q, lse_irq_d, lse_wkup_q, lse_wkup_d;

    always_comb begin
        extf_cnt_d = extf_cnt_q;
        css_trip   = 1'b0;
        if (!css_en || (cur_q != SRC_EXTF) || rise[OSC_EXTF]) begin
            extf_cnt_d = 10'h000;
        end else if (extf_cnt_q != 10'(EXTF_LOSS_CYC)) begin
            extf_cnt_d = extf_cnt_q + 10'h001;
            css_trip   = (extf_cnt_q == 10'(EXTF_LOSS_CYC - 1));
        end
        lse_cnt_d = lse_cnt_q;
        lse_trip  = 1'b0;
        if (!lse_css_en || !sync_lvl[RDY_BASE+OSC_EXT32K] || rise[OSC_EXT32K]) begin
            lse_cnt_d = 16'h0000;
        end else if (lse_cnt_q != 16'(LSE_LOSS_CYC)) begin
            lse_cnt_d = lse_cnt_q + 16'h0001;
            lse_trip  = (lse_cnt_q == 16'(LSE_LOSS_CYC - 1));
        end
        css_flag_d = (css_flag_q & ~css_clr) | css_trip;
        css_irq_d  = css_flag_d & css_irq_en;
        lse_flag_d = (lse_flag_q & ~lse_clr) | lse_trip;
        lse_irq_d  = lse_flag_d & lse_irq_en;
        lse_wkup_d = lse_trip & lse_wkup_en;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            extf_cnt_q <= 10'h000;
            lse_cnt_q  <= 16'h0000;
            css_flag_q <= 1'b0;
            css_irq_q  <= 1'b0;
            lse_flag_q <= 1'b0;
            lse_irq_q  <= 1'b0;
            lse_wkup_q <= 1'b0;
        end else begin
            extf_cnt_q <= extf_cnt_d;
            lse_cnt_q  <= lse_cnt_d;
            css_flag_q <= css_flag_d;
            css_irq_q  <= css_irq_d;
            lse_flag_q <= lse_flag_d;
            lse_irq_q  <= lse_irq_d;
            lse_wkup_q <= lse_wkup_d;
        end
    end

    // Slow-clock measurement: ch0 multispeed per 32 kHz period, ch1 16 MHz per 37 kHz
    logic [1:0][15:0] mcnt_q, mcnt_d, meas_q, meas_d;
    logic [1:0]       mval_q, mval_d, mref, mwin;

    always_comb begin
        mref = {rise[OSC_INT16], rise[OSC_MSRC]};
        mwin = {rise[OSC_INT37K], rise[OSC_EXT32K] & sync_lvl[RDY_BASE+OSC_EXT32K]};
        mcnt_d = mcnt_q;
        meas_d = meas_q;
        mval_d = 2'h0;
        for (int i = 0; i < 2; i++) begin
            if (!meas_en) begin
                mcnt_d[i] = 16'h0000;
            end else if (mwin[i]) begin
                meas_d[i] = mcnt_q[i];
                mval_d[i] = 1'b1;
                mcnt_d[i] = {15'h0000, mref[i]};
            end else if (mref[i] && (mcnt_q[i] != 16'hffff)) begin
                mcnt_d[i] = mcnt_q[i] + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mcnt_q <= '0;
            meas_q <= '0;
            mval_q <= 2'h0;
        end else begin
            mcnt_q <= mcnt_d;
            meas_q <= meas_d;
            mval_q <= mval_d;
        end
    end

    // USB 48 MHz trim; a higher trim code is taken to raise the frequency
    logic [16:0] cnt48_q, cnt48_d;
    logic [5:0]  usb_trim_q, usb_trim_d;
    logic        sof_seen_q, sof_seen_d;

    always_comb begin
        cnt48_d    = cnt48_q;
        usb_trim_d = usb_trim_q;
        sof_seen_d = sof_seen_q;
        if (!usb_en) begin
            cnt48_d    = 17'h0_0000;
            sof_seen_d = 1'b0;
        end else if (usb_sof) begin
            cnt48_d    = {16'h0000, rise[OSC_INT48]};
            sof_seen_d = 1'b1;
            // First frame after enable only starts the count
            if (sof_seen_q) begin
                if ((cnt48_q < 17'(INT48_PER_SOF - USB_TRIM_TOL))
                    && (usb_trim_q != USB_TRIM_MAX)) begin
                    usb_trim_d = usb_trim_q + 6'h01;
                end else if ((cnt48_q > 17'(INT48_PER_SOF + USB_TRIM_TOL))
                    && (usb_trim_q != 6'h00)) begin
                    usb_trim_d = usb_trim_q - 6'h01;
                end
            end
        end else if (rise[OSC_INT48] && (cnt48_q != 17'h1_ffff)) begin
            cnt48_d = cnt48_q + 17'h0_0001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt48_q    <= 17'h0_0000;
            usb_trim_q <= USB_TRIM_RST;
            sof_seen_q <= 1'b0;
        end else begin
            cnt48_q    <= cnt48_d;
            usb_trim_q <= usb_trim_d;
            sof_seen_q <= sof_seen_d;
        end
    end

    // Clock tree; every master source is at most 25 MHz so no bus domain passes 32 MHz; the USB tick runs at 48 MHz
    mcc_div_if ahb_if ();
    mcc_div_if apb1_if ();
    mcc_div_if apb2_if ();

    logic       master_q, master_d, core_q, core_d, mem_q, mem_d;
    logic [7:0] periph_q, periph_d;
    logic       pll_q, pll_d, rtc_q, rtc_d, iwdg_q, iwdg_d, usbt_q, usbt_d;
    logic       mco_src, mco_q, mco_d;
    logic [5:0] osc_en_q, osc_en_d;

    assign ahb_if.tick_in  = master_q;
    assign ahb_if.shift    = ahb_shift;
    assign apb1_if.tick_in = ahb_if.tick_out;
    assign apb1_if.shift   = apb1_shift;
    assign apb2_if.tick_in = ahb_if.tick_out;
    assign apb2_if.shift   = apb2_shift;

    mcc_prescaler u_ahb (.core_clk(core_clk), .resetn(resetn), .dv(ahb_if));
    mcc_prescaler u_apb1 (.core_clk(core_clk), .resetn(resetn), .dv(apb1_if));
    mcc_prescaler u_apb2 (.core_clk(core_clk), .resetn(resetn), .dv(apb2_if));

    always_comb begin
        master_d = pick3(cur_q, rise3);
        core_d   = ahb_if.tick_out & core_gate_en;
        mem_d    = ahb_if.tick_out & mem_gate_en;
        periph_d = {{4{apb2_if.tick_out}}, {4{apb1_if.tick_out}}} & periph_gate_en;
        pll_d    = pll_ref_sel ? rise[OSC_EXTF] : rise[OSC_INT16];
        case (ls_sel)
            LS_EXT32K: rtc_d = rise[OSC_EXT32K];
            LS_INT37K: rtc_d = rise[OSC_INT37K];
            LS_EXTF:   rtc_d = rise[OSC_EXTF];
            default:   rtc_d = 1'b0;
        endcase
        iwdg_d = rise[OSC_INT37K];
        usbt_d = rise[OSC_INT48] & usb_en;
        case (mco_sel)
            MCO_MASTER: mco_src = master_q;
            MCO_INT16:  mco_src = rise[OSC_INT16];
            MCO_MSRC:   mco_src = rise[OSC_MSRC];
            MCO_EXTF:   mco_src = rise[OSC_EXTF];
            MCO_EXT32K: mco_src = rise[OSC_EXT32K];
            MCO_INT37K: mco_src = rise[OSC_INT37K];
            MCO_INT48:  mco_src = rise[OSC_INT48];
            default:    mco_src = 1'b0;
        endcase
        // Pin toggles per tick, so it shows the source halved
        mco_d = (mco_sel == MCO_OFF) ? 1'b0 : (mco_q ^ mco_src);
        osc_en_d             = 6'h00;
        osc_en_d[OSC_MSRC]   = (cur_q == SRC_MSRC) || (tgt_q == SRC_MSRC);
        osc_en_d[OSC_INT16]  = (cur_q == SRC_INT16) || (tgt_q == SRC_INT16) || meas_en;
        osc_en_d[OSC_EXTF]   = (cur_q == SRC_EXTF) || (tgt_q == SRC_EXTF) || pll_ref_sel
                               || (ls_sel == LS_EXTF);
        osc_en_d[OSC_EXT32K] = (ls_sel == LS_EXT32K) || lse_css_en || meas_en;
        osc_en_d[OSC_INT37K] = 1'b1;
        osc_en_d[OSC_INT48]  = usb_en;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            master_q <= 1'b0;
            core_q   <= 1'b0;
            mem_q    <= 1'b0;
            periph_q <= 8'h00;
            pll_q    <= 1'b0;
            rtc_q    <= 1'b0;
            iwdg_q   <= 1'b0;
            usbt_q   <= 1'b0;
            mco_q    <= 1'b0;
            osc_en_q <= OSC_EN_RST;
        end else begin
            master_q <= master_d;
            core_q   <= core_d;
            mem_q    <= mem_d;
            periph_q <= periph_d;
            pll_q    <= pll_d;
            rtc_q    <= rtc_d;
            iwdg_q   <= iwdg_d;
            usbt_q   <= usbt_d;
            mco_q    <= mco_d;
            osc_en_q <= osc_en_d;
        end
    end

    assign osc_en = osc_en_q;
    assign msrc_range_out = range_q;
    assign int16_trim_out = int16_trim_q;
    assign msrc_trim_out = msrc_trim_q;
    assign usb_trim_out = usb_trim_q;
    assign master_clock_cur = cur_q;
    assign switch_busy = (sw_st_q != SW_IDLE);
    assign master_tick = master_q;
    assign ahb_tick = ahb_if.tick_out;
    assign apb1_tick = apb1_if.tick_out;
    assign apb2_tick = apb2_if.tick_out;
    assign core_tick = core_q;
    assign periph_tick = periph_q;
    assign mem_tick = mem_q;
    assign pll_ref_tick = pll_q;
    assign rtc_lcd_tick = rtc_q;
    assign iwdg_tick = iwdg_q;
    assign usb_tick = usbt_q;
    assign msrc_meas = meas_q[0];
    assign lsi_meas = meas_q[1];
    assign meas_valid = mval_q;
    assign css_flag = css_flag_q;
    assign css_irq = css_irq_q;
    assign lse_flag = lse_flag_q;
    assign lse_irq = lse_irq_q;
    assign lse_wkup = lse_wkup_q;
    assign clock_output_pin = mco_q;
endmodule // mcc_top
`default_nettype wire

// ---- sim/mcc_osc_model.sv ----
/* Oscillator bank seen by the clock controller.
 Assumes core_clk timing; rates are in core cycles. */
`timescale 1ns/100ps
`default_nettype none
module mcc_osc_model (
    input  wire logic       core_clk,
    input  wire logic [5:0] osc_en,
    input  wire logic       extf_dead,
    output var  logic [5:0] osc_clk_in,
    output var  logic [3:0] osc_rdy_in
);
    int hp [6] = '{5, 3, 4, 12, 20, 3};
    int cnt [6] = '{default: 0};
    initial {osc_clk_in, osc_rdy_in} = '0;
    // Dead crystal stops but stays ready
    always @(posedge core_clk) begin
        osc_rdy_in <= osc_en[3:0];
        for (int k = 0; k < 6; k++) begin
            cnt[k] <= (cnt[k] + 1) % hp[k];
            if (osc_en[k] && !(k == 2 && extf_dead) && cnt[k] == 0) begin
                osc_clk_in[k] <= ~osc_clk_in[k];
            end
        end
    end
endmodule // mcc_osc_model
`default_nettype wire

// ---- sim/mcc_top_properties.sv ----
/* Port checker for the clock controller.
 Assumes binding into mcc_top. */
`timescale 1ns/100ps
`default_nettype none
module mcc_top_properties
    import mcc_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic [1:0] master_clock_cur,
    input wire logic       switch_busy,
    input wire logic [2:0] msrc_range_out,
    input wire logic       master_tick,
    input wire logic       ahb_tick,
    input wire logic       core_gate_en,
    input wire logic       core_tick,
    input wire logic [7:0] periph_gate_en,
    input wire logic [7:0] periph_tick,
    input wire logic       css_flag,
    input wire logic       css_irq,
    input wire logic [2:0] mco_sel,
    input wire logic       clock_output_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    reset_src_a: assert property ($rose(resetn) |-> master_clock_cur == SRC_MSRC
        && msrc_range_out == MSRC_RANGE_RST) else $error("Bad start state");
    switch_wait_a: assert property ($changed(master_clock_cur) |-> $past(switch_busy))
        else $error("Unrequested switch");
    ahb_div_a: assert property (ahb_tick |-> $past(master_tick))
        else $error("Stray bus tick");
    core_gate_a: assert property ((!core_gate_en)[*3] |-> !core_tick)
        else $error("Core tick while gated");
    periph_gate_a: assert property ($stable(periph_gate_en)[*3] |->
        (periph_tick & ~periph_gate_en) == 8'h00) else $error("Peripheral tick while gated");
    css_move_a: assert property ($rose(css_flag) |-> ##[1:100] master_clock_cur == SRC_INT16)
        else $error("No fallback");
    css_irq_a: assert property (css_irq |-> css_flag || $past(css_flag))
        else $error("Stray interrupt");
    mco_off_a: assert property ((mco_sel == MCO_OFF)[*3] |-> !clock_output_pin)
        else $error("Clock pin active while off");
    cover property ($changed(master_clock_cur));
    cover property ($rose(css_flag));
    cover property ($rose(clock_output_pin));
endmodule // mcc_top_properties
bind mcc_top mcc_top_properties mcc_top_properties_inst (.*);
`default_nettype wire

// ---- sim/mcc_top_tb.sv ----
/* Self-checking bench for the clock controller.
 Assumes the oscillator model on the far side. */
`timescale 1ns/100ps
`default_nettype none
module mcc_top_tb
    import mcc_pkg::*;
;
    logic core_clk, resetn, core_gate_en, mem_gate_en, pll_ref_sel, css_en, css_irq_en, css_clr,
        lse_css_en, lse_irq_en, lse_wkup_en, lse_clr, meas_en, usb_en, usb_sof, switch_busy,
        master_tick, ahb_tick, apb1_tick, apb2_tick, core_tick, mem_tick, pll_ref_tick,
        rtc_lcd_tick, iwdg_tick, usb_tick, css_flag, css_irq, lse_flag, lse_irq, lse_wkup,
        clock_output_pin, extf_dead;
    logic [1:0]  master_clock_sel, ls_sel, master_clock_cur, meas_valid;
    logic [2:0]  msrc_range, ahb_shift, apb1_shift, apb2_shift, mco_sel, msrc_range_out;
    logic [3:0]  osc_rdy_in;
    logic [4:0]  int16_trim_in, int16_trim_out;
    logic [5:0]  osc_clk_in, osc_en, usb_trim_out;
    logic [7:0]  msrc_trim_in, periph_gate_en, periph_tick, msrc_trim_out;
    logic [15:0] msrc_meas, lsi_meas;
    int          errors = 0;
    int          tests_run = 0;
    mcc_top #(.LSE_LOSS_CYC(40)) mcc_top_inst (.*);
    mcc_osc_model mcc_osc_model_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task results;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Stall ends the run
    task sel_wait(input logic [1:0] s);
        int i;
        @(posedge core_clk) master_clock_sel <= s;
        for (i = 0; i < 2000 && master_clock_cur !== s; i++) @(posedge core_clk);
        check(i < 2000, "stalled");
        if (i == 2000) results();
    endtask
    task t_reset;
        #1;
        check(osc_en === OSC_EN_RST && master_clock_cur === SRC_MSRC && usb_trim_out === USB_TRIM_RST
            && int16_trim_out === INT16_TRIM_RST && msrc_range_out === MSRC_RANGE_RST, "reset");
        @(posedge core_clk) resetn <= 1'b1;
        @(posedge core_clk) int16_trim_in <= 5'h0c;
        msrc_range <= MSRC_RANGE_MAX;
        repeat (3) @(posedge core_clk);
        msrc_range <= 3'h7;
        repeat (3) @(posedge core_clk);
        #1;
        check(int16_trim_out === 5'h0c && msrc_range_out === MSRC_RANGE_MAX, "trim");
    endtask
    task t_switch;
        sel_wait(SRC_INT16);
        sel_wait(SRC_EXTF);
        @(posedge core_clk) master_clock_sel <= SRC_RSVD;
        repeat (60) @(posedge core_clk);
        check(master_clock_cur === SRC_EXTF && switch_busy === 1'b0, "reserved");
        sel_wait(SRC_MSRC);
    endtask
    task t_prescale;
        int m, a, p, o;
        {m, a, p, o} = '0;
        @(posedge core_clk) ahb_shift <= 3'h2;
        apb1_shift <= 3'h1;
        mco_sel <= MCO_MASTER;
        repeat (20) @(posedge core_clk);
        for (int i = 0; i < 4000 && m < 32; i++) begin
            @(posedge core_clk);
            #1;
            m += master_tick;
            a += ahb_tick;
            p += apb1_tick;
            o += clock_output_pin;
        end
        check(a >= 7 && a <= 9 && p >= 3 && p <= 5, "bus ratios");
        check(o > 0, "pin idle");
    endtask
    task t_gate;
        int c, g;
        {c, g} = '0;
        @(posedge core_clk) {core_gate_en, mem_gate_en, periph_gate_en} <= 10'h00f;
        repeat (8) @(posedge core_clk);
        repeat (300) begin
            @(posedge core_clk);
            #1;
            c += core_tick | mem_tick | (|periph_tick[7:4]);
            g += periph_tick[0];
        end
        check(c == 0 && g > 0, "gating");
    endtask
    task t_css;
        int i;
        @(posedge core_clk) {css_en, css_irq_en} <= 2'h3;
        sel_wait(SRC_EXTF);
        @(posedge core_clk) extf_dead <= 1'b1;
        for (i = 0; i < 800 && css_flag !== 1'b1; i++) @(posedge core_clk);
        #1;
        check(i >= 480 && i < 800 && css_irq === 1'b1, "crystal loss");
        sel_wait(SRC_INT16);
        @(posedge core_clk) css_clr <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check(css_flag === 1'b0 && master_clock_cur === SRC_INT16, "flag clear");
    endtask
    initial begin
        {resetn, extf_dead, master_clock_sel, int16_trim_in, msrc_trim_in, pll_ref_sel} = '0;
        {ahb_shift, apb1_shift, apb2_shift, ls_sel, mco_sel, css_en, css_irq_en, css_clr} = '0;
        {lse_css_en, lse_irq_en, lse_wkup_en, lse_clr, meas_en, usb_en, usb_sof} = '0;
        {core_gate_en, mem_gate_en, periph_gate_en} = 10'h3ff;
        msrc_range = MSRC_RANGE_RST;
        repeat (8) @(posedge core_clk);
        t_reset;
        t_switch;
        t_prescale;
        t_gate;
        t_css;
        results;
    end
endmodule // mcc_top_tb
`default_nettype wire
